/* design/dcdr_pkg.sv */
// Purpose: Constants for the socket/interrupt control and diagnostic register bank.
// Assumes: Classic Wishbone slave with 32-bit data; each register takes one aligned word.
// Notes:   Byte address of a register is four times its index.
package dcdr_pkg;

  // Register indices and the byte addresses derived from them.
  localparam logic [7:0]  SIC_IDX         = 8'h92;
  localparam logic [7:0]  TRD_IDX         = 8'h93;
  localparam logic [9:0]  SIC_BYTE_ADDR   = {SIC_IDX, 2'b00};
  localparam logic [9:0]  TRD_BYTE_ADDR   = {TRD_IDX, 2'b00};

  // Reset values.
  localparam logic [7:0]  SIC_RESET       = 8'h66;
  localparam logic [7:0]  TRD_RESET       = 8'h61;
  // Bits of the diagnostic register that read back as stored.
  localparam logic [7:0]  TRD_READ_MASK   = 8'hbf;

  // Socket and interrupt control field positions.
  localparam int          SIC_PWR_LOCK    = 7;
  localparam int          SIC_THREE_VOLT  = 6;
  localparam int          SIC_DIAG_FIVE   = 5;
  localparam int          SIC_HOLDER_EN   = 4;
  localparam int          SIC_VENDOR_TEST = 3;
  localparam int          SIC_MODE_HI     = 2;
  localparam int          SIC_MODE_LO     = 1;
  localparam int          SIC_TEST_ZERO   = 0;

  // Test and routing diagnostic field positions.
  localparam int          TRD_ID_MASK     = 7;
  localparam int          TRD_RSVD        = 6;
  localparam int          TRD_CSC_ROUTE   = 5;
  localparam int          TRD_DELAYED_TXN_OFF   = 4;
  localparam int          TRD_LATENCY_EXTEND   = 3;
  localparam int          TRD_CB_DISCARD  = 2;
  localparam int          TRD_PCI_DISCARD = 1;
  localparam int          TRD_ASYNC_EN    = 0;

  // Interrupt signalling modes.
  localparam logic [1:0]  MODE_PAR_PCI    = 2'h0;
  localparam logic [1:0]  MODE_PAR_IRQ    = 2'h1;
  localparam logic [1:0]  MODE_SER_IRQ    = 2'h2;
  localparam logic [1:0]  MODE_SER_ALL    = 2'h3;

  // Legacy config field positions.
  localparam int          LEG_CFG_PCI_BIT = 4;

  // Retry latency limits and discard timeouts, in PCI clock cycles.
  localparam logic [6:0]  LATENCY_SHORT   = 7'h10;
  localparam logic [6:0]  LATENCY_LONG    = 7'h40;
  localparam logic [15:0] DISCARD_SHORT   = 16'h0400;
  localparam logic [15:0] DISCARD_LONG    = 16'h8000;

endpackage : dcdr_pkg

/* design/dcdr_regs.sv */
// Purpose: Socket/interrupt control and test/routing diagnostic registers.
// Assumes: Classic Wishbone slave; all functional inputs are on clk_i.
// Notes:   Every output is registered; derived controls lag a write by one cycle.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps

module dcdr_regs
  import dcdr_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // Clock and reset.
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave.
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic [31:0]       dat_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic              we_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // Socket power.
  input  wire logic              pwr_on_req_i,
  input  wire logic              pwr_off_req_i,
  input  wire logic              d3_state_i,
  output logic                   socket_power_on_o,
  output logic                   socket_power_lock_o,
  output logic                   three_volt_force_o,
  output logic                   diag_bit_five_o,
  output logic                   bus_holder_en_o,
  // Interrupt signalling mode.
  output logic      [1:0]        interrupt_signalling_select_o,
  output logic                   irq_parallel_o,
  output logic                   irq_serial_o,
  output logic                   pci_parallel_o,
  output logic                   pci_serial_o,
  // Identity.
  input  wire logic [15:0]       vendor_id_i,
  input  wire logic [15:0]       device_id_i,
  output logic      [15:0]       vendor_id_rd_o,
  output logic      [15:0]       device_id_rd_o,
  // Status change routing.
  input  wire logic [7:0]        legacy_status_change_config_i,
  input  wire logic [7:0]        legacy_irq_select_i,
  input  wire logic              status_change_i,
  output logic                   csc_to_pci_o,
  output logic                   csc_async_irq_o,
  // Delayed transaction controls.
  output logic                   delayed_txn_off_o,
  output logic      [6:0]        latency_extend_o,
  output logic      [15:0]       cardbus_discard_timeout_o,
  output logic      [15:0]       pci_discard_timeout_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks.

  // The decode needs room for the full byte address of both registers.
  if (ADDR_W < 10)
  begin : g_addr_chk
    $error("ADDR_W too small for register decode.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic        ack;
    logic [7:0]  rdat;
    logic [7:0]  sic;
    logic [7:0]  trd;
    logic        pwr_on;
    logic [3:0]  mode_dec;
    logic [15:0] vid;
    logic [15:0] did;
    logic        csc_pci;
    logic        csc_irq;
    logic [6:0]  lat;
    logic [15:0] cb_to;
    logic [15:0] pci_to;
  } dcdr_state_s;

  dcdr_state_s st_q;
  dcdr_state_s st_d;

  logic        req;
  logic        hit_sic;
  logic        hit_trd;
  logic        wr_now;
  logic [7:0]  wbyte;

  // Decode on word address; byte lane 0 carries the eight data bits.
  assign req     = cyc_i & stb_i;
  assign hit_sic = (adr_i[ADDR_W-1:2] == (ADDR_W-2)'(SIC_IDX));
  assign hit_trd = (adr_i[ADDR_W-1:2] == (ADDR_W-2)'(TRD_IDX));
  assign wr_now  = req & we_i & st_q.ack & sel_i[0];
  assign wbyte   = dat_i[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  // One combinational pass computes bus answer, register writes and controls.
  always_comb
  begin
    st_d = st_q;

    // Ack one cycle after request, dropped the cycle after it was given.
    st_d.ack = req & ~st_q.ack;

    // Read data is latched with the ack; unmapped words read as zero.
    if (req & ~st_q.ack & ~we_i)
    begin
      if (hit_sic)
        st_d.rdat = st_q.sic;
      else if (hit_trd)
        st_d.rdat = st_q.trd & TRD_READ_MASK;
      else
        st_d.rdat = 8'h00;
    end

    // Writes land on the ack edge, so read data of the same access is stable.
    if (wr_now & hit_sic)
      st_d.sic = wbyte;
    if (wr_now & hit_trd)
      st_d.trd = wbyte;

    // Power lock in D3 swallows power-down requests; power-up wins a tie.
    if (pwr_on_req_i)
      st_d.pwr_on = 1'b1;
    else if (pwr_off_req_i & ~(st_q.sic[SIC_PWR_LOCK] & d3_state_i))
      st_d.pwr_on = 1'b0;

    // Decoded mode: {irq parallel, irq serial, pci parallel, pci serial}.
    unique case (st_q.sic[SIC_MODE_HI:SIC_MODE_LO])
      MODE_PAR_PCI: st_d.mode_dec = 4'h2;
      MODE_PAR_IRQ: st_d.mode_dec = 4'ha;
      MODE_SER_IRQ: st_d.mode_dec = 4'h6;
      MODE_SER_ALL: st_d.mode_dec = 4'h5;
    endcase

    // Masked identity hides the part from enumeration software.
    st_d.vid = st_q.trd[TRD_ID_MASK] ? 16'hffff : vendor_id_i;
    st_d.did = st_q.trd[TRD_ID_MASK] ? 16'hffff : device_id_i;

    // Routing select picks which legacy field decides PCI delivery.
    st_d.csc_pci = st_q.trd[TRD_CSC_ROUTE]
                 ? (legacy_irq_select_i[7:4] == 4'h0)
                 : legacy_status_change_config_i[LEG_CFG_PCI_BIT];

    // Status change raises the async line only while enabled.
    st_d.csc_irq = status_change_i & st_q.trd[TRD_ASYNC_EN];

    st_d.lat    = st_q.trd[TRD_LATENCY_EXTEND] ? LATENCY_LONG : LATENCY_SHORT;
    st_d.cb_to  = st_q.trd[TRD_CB_DISCARD] ? DISCARD_SHORT : DISCARD_LONG;
    st_d.pci_to = st_q.trd[TRD_PCI_DISCARD] ? DISCARD_SHORT : DISCARD_LONG;

    if (rst_i)
    begin
      st_d        = '0;
      st_d.sic    = SIC_RESET;
      st_d.trd    = TRD_RESET;
      st_d.mode_dec = 4'h5;
      st_d.lat    = LATENCY_SHORT;
      st_d.cb_to  = DISCARD_LONG;
      st_d.pci_to = DISCARD_LONG;
    end
  end

  // Single state register; reset is folded into the next-state logic.
  always_ff @(posedge clk_i)
  begin
    st_q <= st_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // All outputs are flip-flop bits; bits 3 and 0 are stored but drive nothing.
  assign dat_o                         = {24'h000000, st_q.rdat};
  assign ack_o                         = st_q.ack;
  assign socket_power_on_o             = st_q.pwr_on;
  assign socket_power_lock_o           = st_q.sic[SIC_PWR_LOCK];
  assign three_volt_force_o            = st_q.sic[SIC_THREE_VOLT];
  assign diag_bit_five_o               = st_q.sic[SIC_DIAG_FIVE];
  assign bus_holder_en_o               = st_q.sic[SIC_HOLDER_EN];
  assign interrupt_signalling_select_o = st_q.sic[SIC_MODE_HI:SIC_MODE_LO];
  assign irq_parallel_o                = st_q.mode_dec[3];
  assign irq_serial_o                  = st_q.mode_dec[2];
  assign pci_parallel_o                = st_q.mode_dec[1];
  assign pci_serial_o                  = st_q.mode_dec[0];
  assign vendor_id_rd_o                = st_q.vid;
  assign device_id_rd_o                = st_q.did;
  assign csc_to_pci_o                  = st_q.csc_pci;
  assign csc_async_irq_o               = st_q.csc_irq;
  assign delayed_txn_off_o             = st_q.trd[TRD_DELAYED_TXN_OFF];
  assign latency_extend_o              = st_q.lat;
  assign cardbus_discard_timeout_o     = st_q.cb_to;
  assign pci_discard_timeout_o         = st_q.pci_to;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // A locked socket in D3 is never powered down by a request alone.
  power_lock_hold_a: assert property (
    (socket_power_lock_o && d3_state_i && socket_power_on_o && !pwr_on_req_i)
      |=> socket_power_on_o)
    else $error("Locked socket powered down in D3.");

  // Reset loads both defaults, seen on the first cycle after release.
  reset_defaults_a: assert property (
    $fell(rst_i) |-> (st_q.sic == SIC_RESET && st_q.trd == TRD_RESET))
    else $error("Register defaults wrong after reset.");

  // A write to the control word shows up on the holder enable one edge on.
  holder_write_a: assert property (
    (wr_now && hit_sic) |=> (bus_holder_en_o == $past(dat_i[SIC_HOLDER_EN])))
    else $error("Holder enable does not follow write.");

  // Serial PCI is reported only for mode 11.
  mode_decode_a: assert property (
    (interrupt_signalling_select_o == MODE_SER_ALL && $stable(st_q.sic))
      |=> (pci_serial_o && irq_serial_o && !pci_parallel_o && !irq_parallel_o))
    else $error("Mode 11 decode wrong.");

  // Mode 00 gives parallel PCI only.
  mode_par_pci_a: assert property (
    (interrupt_signalling_select_o == MODE_PAR_PCI && $stable(st_q.sic))
      |=> (pci_parallel_o && !irq_serial_o && !irq_parallel_o && !pci_serial_o))
    else $error("Mode 00 decode wrong.");

  // Masked identity reads all ones.
  id_mask_a: assert property (
    st_q.trd[TRD_ID_MASK] |=> (vendor_id_rd_o == 16'hffff && device_id_rd_o == 16'hffff))
    else $error("Identity not masked.");

  // Unmasked identity passes true values.
  id_true_a: assert property (
    !st_q.trd[TRD_ID_MASK]
      |=> (vendor_id_rd_o == $past(vendor_id_i) && device_id_rd_o == $past(device_id_i)))
    else $error("True identity not returned.");

  // Bit six of the diagnostic word never reads back as one.
  rsvd_read_zero_a: assert property (
    (ack_o && !we_i && hit_trd) |-> (dat_o[TRD_RSVD] == 1'b0))
    else $error("Reserved diagnostic bit read as one.");

  // Routing through the legacy IRQ select field.
  csc_route_a: assert property (
    (st_q.trd[TRD_CSC_ROUTE] && legacy_irq_select_i[7:4] == 4'h0) |=> csc_to_pci_o)
    else $error("Status change not routed to PCI.");

  // Async interrupt only with enable set.
  async_gate_a: assert property (
    (status_change_i && !st_q.trd[TRD_ASYNC_EN]) |=> !csc_async_irq_o)
    else $error("Async interrupt raised while disabled.");

  // Retry extend chooses 64, otherwise 16.
  latency_sel_a: assert property (
    ##1 (latency_extend_o == ($past(st_q.trd[TRD_LATENCY_EXTEND]) ? 7'h40 : 7'h10)))
    else $error("Retry latency limit wrong.");

  // Card bus discard timer select.
  discard_sel_a: assert property (
    ##1 (cardbus_discard_timeout_o ==
         ($past(st_q.trd[TRD_CB_DISCARD]) ? 16'h0400 : 16'h8000)))
    else $error("Card bus discard timeout wrong.");

  // PCI discard timer select.
  pci_discard_a: assert property (
    ##1 (pci_discard_timeout_o ==
         ($past(st_q.trd[TRD_PCI_DISCARD]) ? DISCARD_SHORT : DISCARD_LONG)))
    else $error("PCI discard timeout wrong.");

  // Mode 01 gives parallel IRQ beside parallel PCI.
  mode_par_irq_a: assert property (
    (interrupt_signalling_select_o == MODE_PAR_IRQ)
      |=> (irq_parallel_o && pci_parallel_o && !irq_serial_o && !pci_serial_o))
    else $error("Mode 01 decode wrong.");

  // Mode 10 gives serial IRQ beside parallel PCI.
  mode_ser_irq_a: assert property (
    (interrupt_signalling_select_o == MODE_SER_IRQ)
      |=> (irq_serial_o && pci_parallel_o && !irq_parallel_o && !pci_serial_o))
    else $error("Mode 10 decode wrong.");

  // A diagnostic write reaches the delayed transaction control one edge later.
  retry_write_a: assert property (
    (wr_now && hit_trd) |=> (delayed_txn_off_o == $past(dat_i[TRD_DELAYED_TXN_OFF])))
    else $error("Retry disable does not follow write.");

  // Ack is a single-cycle pulse.
  ack_pulse_a: assert property (
    ack_o |=> !ack_o)
    else $error("Ack held longer than one cycle.");

endmodule : dcdr_regs

/* test/tb_top.sv */
// Purpose: Self-checking bench for the socket/interrupt control and diagnostic registers.
// Assumes: Classic Wishbone single cycles; every derived output settles within 3 cycles of a write.
// Notes:   Reads are checked from a queue of notes; outputs are checked after each write with byte lane 0 selected.
`timescale 1ns/1ps

module tb_top
  import dcdr_pkg::*;
;
  logic clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0;
  logic [11:0] adr_i = '0;
  logic [31:0] dat_i = '0;
  logic [3:0] sel_i = '0;
  logic pwr_on_req_i = 0, pwr_off_req_i = 0, d3_state_i = 0, status_change_i = 0;
  logic [15:0] vendor_id_i = 16'h1234, device_id_i = 16'h5678;
  logic [7:0] legacy_status_change_config_i = '0, legacy_irq_select_i = '0;
  logic [31:0] dat_o;
  logic ack_o, socket_power_on_o, socket_power_lock_o, three_volt_force_o, diag_bit_five_o;
  logic bus_holder_en_o, irq_parallel_o, irq_serial_o, pci_parallel_o, pci_serial_o;
  logic [1:0] interrupt_signalling_select_o;
  logic [15:0] vendor_id_rd_o, device_id_rd_o, cardbus_discard_timeout_o, pci_discard_timeout_o;
  logic csc_to_pci_o, csc_async_irq_o, delayed_txn_off_o;
  logic [6:0] latency_extend_o;
  logic [7:0] exp_q[$];
  int n_errors = 0, checks_done = 0;
  localparam logic [11:0] CTRL = {2'b00, SIC_BYTE_ADDR}, DIAG = {2'b00, TRD_BYTE_ADDR};

  dcdr_regs dut (.clk_i, .rst_i, .adr_i, .dat_i, .sel_i, .we_i, .cyc_i, .stb_i, .dat_o,
    .ack_o, .pwr_on_req_i, .pwr_off_req_i, .d3_state_i, .socket_power_on_o,
    .socket_power_lock_o, .three_volt_force_o, .diag_bit_five_o, .bus_holder_en_o,
    .interrupt_signalling_select_o, .irq_parallel_o, .irq_serial_o, .pci_parallel_o,
    .pci_serial_o, .vendor_id_i, .device_id_i, .vendor_id_rd_o, .device_id_rd_o,
    .legacy_status_change_config_i, .legacy_irq_select_i, .status_change_i, .csc_to_pci_o,
    .csc_async_irq_o, .delayed_txn_off_o, .latency_extend_o, .cardbus_discard_timeout_o,
    .pci_discard_timeout_o);

  // Free-running 50 MHz clock.
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare one value and count it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One classic cycle; the request stands until ack is sampled high.
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {1'b1, 1'b1, w, a, 24'h0, d, s};
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 50)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 50) chk(0, 1, "ack timeout");
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask : bus

  // A read notes its expected byte; the monitor judges it.
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00, 4'hf);
  endtask : rd

  // Reads are judged at the edge that samples ack high, where a classic master takes data.
  always @(posedge clk_i)
  begin
    if (ack_o === 1'b1 && we_i === 1'b0)
      if (exp_q.size() == 0) chk(1, 0, "read with no note");
      else chk(dat_o, {24'h0, exp_q.pop_front()}, "read data");
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // Cuts a hang short; the whole run needs well under 5000 cycles.
  initial
  begin
    #(20 * 20000);
    n_errors++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    logic [7:0] c, d, irq_sel;
    logic [3:0] dec;
    void'($urandom(32'h4935));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CTRL, SIC_RESET);
    rd(DIAG, 8'h21);
    rd(12'h100, 8'h00);
    chk(three_volt_force_o, 1, "3v reset");
    chk(diag_bit_five_o, 1, "bit5 reset");
    chk(bus_holder_en_o, 0, "holder reset");
    chk({irq_serial_o, pci_serial_o}, 2'b11, "mode reset");
    bus(1'b1, CTRL, 8'h00, 4'he);
    rd(CTRL, SIC_RESET);
    // Every mode, random upper bits; test bits 3 and 0 are written as 0.
    for (int m = 0; m < 4; m++)
    begin
      c = (8'($urandom) & 8'hf0) | 8'(m << 1);
      bus(1'b1, CTRL, c, 4'h1);
      repeat (3) @(posedge clk_i);
      rd(CTRL, c);
      dec = (m == 0) ? 4'b0010 : (m == 1) ? 4'b1010 : (m == 2) ? 4'b0110 : 4'b0101;
      chk({irq_parallel_o, irq_serial_o, pci_parallel_o, pci_serial_o}, dec, "mode");
      chk(interrupt_signalling_select_o, m, "mode bits");
      chk({socket_power_lock_o, three_volt_force_o, diag_bit_five_o, bus_holder_en_o},
          c[7:4], "ctrl bits");
    end
    // Power lock in D3 ignores power-down, released once out of D3.
    bus(1'b1, CTRL, 8'h80, 4'h1);
    {pwr_on_req_i, d3_state_i} <= 2'b11;
    @(posedge clk_i);
    {pwr_on_req_i, pwr_off_req_i} <= 2'b01;
    repeat (3) @(posedge clk_i);
    chk(socket_power_on_o, 1, "locked power");
    d3_state_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(socket_power_on_o, 0, "unlocked power");
    pwr_off_req_i <= 1'b0;
    // Random diagnostic settings against random side inputs.
    for (int i = 0; i < 24; i++)
    begin
      d = 8'($urandom);
      // Every third pass clears the upper legacy IRQ field so PCI routing is taken when the routing select bit is set.
      irq_sel = (i % 3 == 0) ? 8'h0f : 8'($urandom);
      legacy_status_change_config_i <= 8'($urandom);
      legacy_irq_select_i <= irq_sel;
      {vendor_id_i, device_id_i} <= $urandom;
      status_change_i <= 1'($urandom);
      bus(1'b1, DIAG, d, 4'h1);
      repeat (3) @(posedge clk_i);
      rd(DIAG, d & 8'hbf);
      chk(vendor_id_rd_o, d[7] ? 16'hffff : vendor_id_i, "vendor id");
      chk(device_id_rd_o, d[7] ? 16'hffff : device_id_i, "device id");
      chk(csc_to_pci_o, d[5] ? (legacy_irq_select_i[7:4] == 4'h0)
          : legacy_status_change_config_i[4], "routing");
      chk(delayed_txn_off_o, d[4], "retry off");
      chk(latency_extend_o, d[3] ? 7'h40 : 7'h10, "latency");
      chk(cardbus_discard_timeout_o, d[2] ? 16'h0400 : 16'h8000, "cb discard");
      chk(pci_discard_timeout_o, d[1] ? 16'h0400 : 16'h8000, "pci discard");
      chk(csc_async_irq_o, d[0] & status_change_i, "async");
    end
    // A reset in mid-run must bring back both defaults over written values.
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CTRL, SIC_RESET);
    rd(DIAG, 8'h21);
    chk(three_volt_force_o, 1, "3v after reset");
    chk(diag_bit_five_o, 1, "bit5 after reset");
    chk({irq_serial_o, pci_serial_o}, 2'b11, "mode after reset");
    repeat (3) @(posedge clk_i);
    chk(exp_q.size(), 0, "notes left");
    report_and_stop();
  end

endmodule : tb_top
